// File: design/srp_top.sv
// serial register port with two-level interrupt tree
`timescale 1ns/1ps
`include "srp_params.svh"

// Functional notes
// - decode 1024 byte-wide addresses; unmapped ones read zero, ignore writes
// - mode 1 link: clock idles low, bits sampled on falling edge
// - data output undriven while select is high
// - frame is direction, 10-bit address, 5 dead bits, 8 data bits
// - on reads, input after address is ignored; addressed byte is sent
// - on reads, output is zero during address and dead bits
// - further read bytes in one transfer come from incremented addresses
// - write data committed at the 24th falling clock edge
// - up to seven further write packets accepted while select stays low
// - alert output is a level, high while an unmasked event pends
// - flags latch and hold until a read clears them
// - mask bit one blocks the alert only; unmasking a set flag alerts
// - alert needs both second-level and top-level masks clear
// - top-level flag set by rising edge of its group's flag OR
// - top-level read clears only captured bits, right after the strobe
// - top-level read leaves second-level flags untouched
// - second-level read clears only captured bits; new events still alert
// - active level source is cleared by the pulse then sets again
// - pin events have no masks; control bits 5:4 prevent them
module srp_top
  import srp_pkg::*;
#(
  parameter int MAX_PACKETS = `SRP_MAX_PACKETS
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       serial_clock_in_i,
  input  wire logic       serial_select_n_i,
  input  wire logic       serial_data_in_i,
  output logic            serial_data_out_o,
  output logic            serial_data_oe_o,
  output logic            host_alert_out_o,
  input  wire logic       power_button_event_i,
  input  wire logic [7:0] converter_src_i,
  input  wire logic [7:0] clock_alarm_src_i,
  input  wire logic [7:0] pin_edge_src_i,
  input  wire logic [7:0] regulator_fault_src_i
);
  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic [2:0]                  pin_meta_reg;
  logic [2:0]                  pin_sync_reg;
  logic                        sclk_prev_reg;
  logic                        sclk_s;
  logic                        sel_n_s;
  logic                        mosi_s;
  logic                        fall;
  logic                        rise;

  // two flops per pin before any logic looks at them
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_meta_reg <= 3'h4;
      pin_sync_reg <= 3'h4;
    end else begin
      pin_meta_reg <= {serial_select_n_i, serial_clock_in_i, serial_data_in_i};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  assign sel_n_s = pin_sync_reg[2];
  assign sclk_s  = pin_sync_reg[1];
  assign mosi_s  = pin_sync_reg[0];

  // edge finder on the synchronised link clock
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sclk_prev_reg <= 1'b0;
    end else begin
      sclk_prev_reg <= sclk_s;
    end
  end

  assign fall = sclk_prev_reg & ~sclk_s;
  assign rise = ~sclk_prev_reg & sclk_s;

  // ----------------------------------------------------------------------
  // frame sequencer
  // ----------------------------------------------------------------------
  srp_state_e                  state_reg;
  logic [`SRP_CNT_W-1:0]       cnt_reg;
  logic [`SRP_PKT_W-1:0]       pkt_reg;
  logic                        write_reg;
  logic [`SRP_ADDR_W-1:0]      addr_reg;
  logic [`SRP_DATA_W-2:0]      rx_reg;
  logic [`SRP_ADDR_W-1:0]      rd_addr;
  logic                        strobe;
  logic                        commit;
  logic                        pkt_end;
  logic                        more_reg;

  assign pkt_end = fall && (state_reg == SRP_FRAME) && (cnt_reg == `SRP_BIT_LAST);
  assign commit  = pkt_end && write_reg;
  // later bytes strobe at their first rising edge, so an unread byte clears nothing
  assign strobe  = (state_reg == SRP_FRAME) && !write_reg &&
                   ((fall && (cnt_reg == `SRP_BIT_DEAD_LAST)) ||
                    (rise && more_reg && (cnt_reg == `SRP_BIT_DATA_FIRST)));
  // auto-increment on the byte boundary of a read
  assign rd_addr = (cnt_reg == `SRP_BIT_LAST) ? 10'(addr_reg + 10'h001) : addr_reg;

  // state: select low opens a frame, select high ends everything
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= SRP_IDLE;
    end else if (sel_n_s) begin
      state_reg <= SRP_IDLE;
    end else begin
      unique case (state_reg)
        SRP_IDLE:  state_reg <= SRP_FRAME;
        SRP_FRAME: begin
          if (commit && (int'(pkt_reg) == MAX_PACKETS - 1)) begin
            state_reg <= SRP_HALT;
          end
        end
        SRP_HALT:  state_reg <= SRP_HALT;
      endcase
    end
  end

  // bit and packet counters
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
      pkt_reg <= '0;
    end else if (state_reg != SRP_FRAME) begin
      cnt_reg <= '0;
      pkt_reg <= '0;
    end else if (pkt_end) begin
      cnt_reg <= write_reg ? '0 : `SRP_BIT_DATA_FIRST;
      pkt_reg <= write_reg ? 3'(pkt_reg + 3'h1) : pkt_reg;
    end else if (fall) begin
      cnt_reg <= 5'(cnt_reg + 5'h01);
    end
  end

  // a finished read byte arms the fetch of the next address
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      more_reg <= 1'b0;
    end else if (sel_n_s) begin
      more_reg <= 1'b0;
    end else if (pkt_end && !write_reg) begin
      more_reg <= 1'b1;
    end else if (rise) begin
      more_reg <= 1'b0;
    end
  end

  // header capture: direction then address, most significant first
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      write_reg <= 1'b0;
      addr_reg  <= '0;
      rx_reg    <= '0;
    end else if (fall && (state_reg == SRP_FRAME)) begin
      rx_reg <= {rx_reg[`SRP_DATA_W-3:0], mosi_s};
      if (cnt_reg == `SRP_BIT_DIR) begin
        write_reg <= mosi_s;
      end else if (cnt_reg <= `SRP_BIT_ADDR_LAST) begin
        addr_reg <= {addr_reg[`SRP_ADDR_W-2:0], mosi_s};
      end else if (cnt_reg == `SRP_BIT_LAST && !write_reg) begin
        addr_reg <= rd_addr;
      end
    end
  end

  // ----------------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------------
  srp_byte_t                   top_masks_reg;
  srp_byte_t                   vr_masks_reg;
  srp_byte_t                   adc_masks_reg;
  srp_byte_t                   pin_ctl_reg [0:7];
  srp_byte_t                   top_flags;
  srp_byte_t                   rtc_flags;
  srp_byte_t                   vr_flags;
  srp_byte_t                   adc_flags;
  srp_byte_t                   pin_flags;
  srp_byte_t                   wr_data;
  srp_byte_t                   rd_data;

  assign wr_data = {rx_reg, mosi_s};

  // masks and pin controls written at the commit edge; flags are read-only
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      top_masks_reg <= `SRP_RST_TOP_MASKS;
      vr_masks_reg  <= `SRP_RST_VR_MASKS;
      adc_masks_reg <= `SRP_RST_ADC_MASKS;
      for (int i = 0; i < 8; i++) begin
        pin_ctl_reg[i] <= `SRP_RST_PIN_CTL;
      end
    end else if (commit) begin
      unique case (addr_reg)
        `SRP_ADDR_TOP_MASKS: top_masks_reg <= wr_data;
        `SRP_ADDR_VR_MASKS:  vr_masks_reg  <= wr_data;
        `SRP_ADDR_ADC_MASKS: adc_masks_reg <= wr_data;
        default: begin
          if ({addr_reg[`SRP_ADDR_W-1:3], 3'h0} == `SRP_ADDR_PIN_CTL0) begin
            pin_ctl_reg[addr_reg[2:0]] <= wr_data;
          end
        end
      endcase
    end
  end

  // read decode; unpopulated addresses return zero
  always_comb begin
    unique case (rd_addr)
      `SRP_ADDR_TOP_FLAGS: rd_data = top_flags;
      `SRP_ADDR_TOP_MASKS: rd_data = top_masks_reg;
      `SRP_ADDR_RTC_FLAGS: rd_data = rtc_flags;
      `SRP_ADDR_VR_FLAGS:  rd_data = vr_flags;
      `SRP_ADDR_VR_MASKS:  rd_data = vr_masks_reg;
      `SRP_ADDR_ADC_FLAGS: rd_data = adc_flags;
      `SRP_ADDR_ADC_MASKS: rd_data = adc_masks_reg;
      `SRP_ADDR_PIN_FLAGS: rd_data = pin_flags;
      default: begin
        if ({rd_addr[`SRP_ADDR_W-1:3], 3'h0} == `SRP_ADDR_PIN_CTL0) begin
          rd_data = pin_ctl_reg[rd_addr[2:0]];
        end else begin
          rd_data = 8'h00;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // serial output
  // ----------------------------------------------------------------------
  srp_byte_t                   tx_reg;
  logic                        miso_reg;
  logic                        oe_reg;
  srp_byte_t                   tx_src;

  // a follow-on byte is loaded and its first bit launched at the same rising edge
  assign tx_src = strobe ? rd_data : tx_reg;

  // load at the strobe, launch on rising edges only in the data bits
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_reg   <= 8'h00;
      miso_reg <= 1'b0;
      oe_reg   <= 1'b0;
    end else begin
      oe_reg <= ~sel_n_s;
      if (sel_n_s) begin
        miso_reg <= 1'b0;
      end else if (strobe && fall) begin
        tx_reg <= rd_data;
      end else if (rise) begin
        if (state_reg == SRP_FRAME && !write_reg && cnt_reg >= `SRP_BIT_DATA_FIRST) begin
          miso_reg <= tx_src[7];
          tx_reg   <= {tx_src[6:0], 1'b0};
        end else begin
          miso_reg <= 1'b0;
        end
      end
    end
  end

  assign serial_data_out_o = miso_reg;
  assign serial_data_oe_o  = oe_reg;

  // ----------------------------------------------------------------------
  // clear-on-read pulses
  // ----------------------------------------------------------------------
  srp_byte_t                   clr_top_reg;
  srp_byte_t                   clr_rtc_reg;
  srp_byte_t                   clr_vr_reg;
  srp_byte_t                   clr_adc_reg;
  srp_byte_t                   clr_pin_reg;

  // the cycle after the strobe, clear exactly what the strobe captured
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      clr_top_reg <= 8'h00;
      clr_rtc_reg <= 8'h00;
      clr_vr_reg  <= 8'h00;
      clr_adc_reg <= 8'h00;
      clr_pin_reg <= 8'h00;
    end else begin
      clr_top_reg <= (strobe && rd_addr == `SRP_ADDR_TOP_FLAGS) ? rd_data : 8'h00;
      clr_rtc_reg <= (strobe && rd_addr == `SRP_ADDR_RTC_FLAGS) ? rd_data : 8'h00;
      clr_vr_reg  <= (strobe && rd_addr == `SRP_ADDR_VR_FLAGS)  ? rd_data : 8'h00;
      clr_adc_reg <= (strobe && rd_addr == `SRP_ADDR_ADC_FLAGS) ? rd_data : 8'h00;
      clr_pin_reg <= (strobe && rd_addr == `SRP_ADDR_PIN_FLAGS) ? rd_data : 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // second-level flags
  // ----------------------------------------------------------------------
  srp_byte_t                   pin_src;

  // pin events pass only when their prevention field is zero
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pin_src[i] = pin_edge_src_i[i] &&
                   (pin_ctl_reg[i][`SRP_PREVENT_HI:`SRP_PREVENT_LO] == 2'b00);
    end
  end

  srp_flag_bank #(.WIDTH(8)) u_rtc_bank (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .src_i  (clock_alarm_src_i & `SRP_VALID_RTC),
    .clr_i  (clr_rtc_reg),
    .flag_o (rtc_flags)
  );

  srp_flag_bank #(.WIDTH(8)) u_vr_bank (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .src_i  (regulator_fault_src_i & `SRP_VALID_VR),
    .clr_i  (clr_vr_reg),
    .flag_o (vr_flags)
  );

  srp_flag_bank #(.WIDTH(8)) u_adc_bank (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .src_i  (converter_src_i & `SRP_VALID_ADC),
    .clr_i  (clr_adc_reg),
    .flag_o (adc_flags)
  );

  srp_flag_bank #(.WIDTH(8)) u_pin_bank (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .src_i  (pin_src),
    .clr_i  (clr_pin_reg),
    .flag_o (pin_flags)
  );

  // ----------------------------------------------------------------------
  // top-level flags and alert
  // ----------------------------------------------------------------------
  srp_byte_t                   grp_or;
  srp_byte_t                   grp_prev_reg;
  srp_byte_t                   grp_ok;
  logic                        alert_reg;

  // group ORs ignore masks; masks only gate the alert
  always_comb begin
    grp_or = 8'h00;
    grp_or[`SRP_TOP_POWER_BUTTON_EVENT] = power_button_event_i;
    grp_or[`SRP_TOP_ADC]    = |adc_flags;
    grp_or[`SRP_TOP_RTC]    = |rtc_flags;
    grp_or[`SRP_TOP_PIN]    = |pin_flags;
    grp_or[`SRP_TOP_VR]     = |vr_flags;
    grp_ok = 8'h00;
    grp_ok[`SRP_TOP_POWER_BUTTON_EVENT] = 1'b1;
    grp_ok[`SRP_TOP_ADC]    = |(adc_flags & ~adc_masks_reg);
    grp_ok[`SRP_TOP_RTC]    = |rtc_flags;
    grp_ok[`SRP_TOP_PIN]    = |pin_flags;
    grp_ok[`SRP_TOP_VR]     = |(vr_flags & ~vr_masks_reg);
  end

  // previous group levels for the rising-edge set
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      grp_prev_reg <= 8'h00;
    end else begin
      grp_prev_reg <= grp_or;
    end
  end

  // second-level flags are never touched by a top-level clear
  srp_flag_bank #(.WIDTH(8)) u_top_bank (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .src_i  (grp_or & ~grp_prev_reg),
    .clr_i  (clr_top_reg),
    .flag_o (top_flags)
  );

  // level alert from unmasked top-level flags
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      alert_reg <= 1'b0;
    end else begin
      alert_reg <= |(top_flags & ~top_masks_reg & grp_ok);
    end
  end

  assign host_alert_out_o = alert_reg;
endmodule // srp_top

// File: design/srp_params.svh
// constants for the serial register port and its interrupt tree
`ifndef SRP_PARAMS_SVH
`define SRP_PARAMS_SVH

// ----------------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------------
`define SRP_ADDR_W          10
`define SRP_DATA_W          8
`define SRP_CNT_W           5
`define SRP_BIT_DIR         5'd0
`define SRP_BIT_ADDR_LAST   5'd10
`define SRP_BIT_DEAD_LAST   5'd15
`define SRP_BIT_DATA_FIRST  5'd16
`define SRP_BIT_LAST        5'd23
`define SRP_MAX_PACKETS     8
`define SRP_PKT_W           3

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define SRP_ADDR_TOP_FLAGS  10'h004
`define SRP_ADDR_TOP_MASKS  10'h005
`define SRP_ADDR_RTC_FLAGS  10'h01c
`define SRP_ADDR_VR_FLAGS   10'h030
`define SRP_ADDR_VR_MASKS   10'h031
`define SRP_ADDR_ADC_FLAGS  10'h05f
`define SRP_ADDR_ADC_MASKS  10'h060
`define SRP_ADDR_PIN_FLAGS  10'h0e8
`define SRP_ADDR_PIN_CTL0   10'h0e0

// ----------------------------------------------------------------------
// reset values and implemented bits
// ----------------------------------------------------------------------
`define SRP_RST_FLAGS       8'h00
`define SRP_RST_TOP_MASKS   8'hfa
`define SRP_RST_VR_MASKS    8'h03
`define SRP_RST_ADC_MASKS   8'h00
`define SRP_RST_PIN_CTL     8'h00
`define SRP_VALID_RTC       8'hb0
`define SRP_VALID_VR        8'h07
`define SRP_VALID_ADC       8'h07

// ----------------------------------------------------------------------
// top-level bit positions and pin control field
// ----------------------------------------------------------------------
`define SRP_TOP_POWER_BUTTON_EVENT      0
`define SRP_TOP_ADC         1
`define SRP_TOP_RTC         3
`define SRP_TOP_PIN         4
`define SRP_TOP_VR          5
`define SRP_PREVENT_HI      5
`define SRP_PREVENT_LO      4

`endif

// File: design/srp_pkg.sv
// types shared by the serial register port
package srp_pkg;
  typedef enum logic [1:0] {
    SRP_IDLE,
    SRP_FRAME,
    SRP_HALT
  } srp_state_e;
  typedef logic [7:0] srp_byte_t;
endpackage

// File: design/srp_flag_bank.sv
// latched event flags with capture-exact clear-on-read
`timescale 1ns/1ps
module srp_flag_bank #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] src_i,
  input  wire logic [WIDTH-1:0] clr_i,
  output logic      [WIDTH-1:0] flag_o
);
  logic [WIDTH-1:0] flag_reg;
  logic [WIDTH-1:0] pend_reg;
  logic [WIDTH-1:0] flag_next;

  // cleared bits drop for the clear cycle; an event in that cycle re-sets next
  always_comb begin
    flag_next = (flag_reg & ~clr_i) | (src_i & ~clr_i) | pend_reg;
  end

  // flags and held-over events
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flag_reg <= '0;
      pend_reg <= '0;
    end else begin
      flag_reg <= flag_next;
      pend_reg <= src_i & clr_i;
    end
  end

  assign flag_o = flag_reg;
endmodule // srp_flag_bank

// File: verif/srp_top_sva.sv
// checker for the serial register port and its alert output
`timescale 1ns/1ps
module srp_top_sva
  import srp_pkg::*;
#(
  parameter int MAX_PACKETS = 8
) (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       serial_clock_in_i,
  input wire logic       serial_select_n_i,
  input wire logic       serial_data_in_i,
  input wire logic       serial_data_out_o,
  input wire logic       serial_data_oe_o,
  input wire logic       host_alert_out_o,
  input wire logic       power_button_event_i,
  input wire logic [7:0] converter_src_i,
  input wire logic [7:0] clock_alarm_src_i,
  input wire logic [7:0] pin_edge_src_i,
  input wire logic [7:0] regulator_fault_src_i
);
  logic       link_q;
  logic [7:0] fall_cnt;
  logic [3:0] rise_age;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // falling link edges in the current frame, cleared while deselected
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fall_cnt <= 8'h00;
    end else if (serial_select_n_i) begin
      fall_cnt <= 8'h00;
    end else if (link_q && !serial_clock_in_i && fall_cnt != 8'hff) begin
      fall_cnt <= fall_cnt + 8'h01;
    end
  end

  // cycles since the last rising link edge, saturating
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      link_q   <= 1'b0;
      rise_age <= 4'hf;
    end else begin
      link_q <= serial_clock_in_i;
      if (!link_q && serial_clock_in_i) begin
        rise_age <= 4'h0;
      end else if (rise_age != 4'hf) begin
        rise_age <= rise_age + 4'h1;
      end
    end
  end

  sequence s_sel_high;
    serial_select_n_i [*5];
  endsequence
  sequence s_sel_low;
    !serial_select_n_i [*5];
  endsequence
  sequence s_idle_alert;
    serial_select_n_i [*8] ##0 host_alert_out_o;
  endsequence

  property p_oe_off;
    s_sel_high |-> !serial_data_oe_o;
  endproperty
  property p_oe_on;
    s_sel_low |-> serial_data_oe_o;
  endproperty
  property p_out_idle;
    serial_select_n_i [*8] |-> !serial_data_out_o;
  endproperty
  property p_out_zero_head;
    (!serial_select_n_i && fall_cnt < 8'd16) |-> !serial_data_out_o;
  endproperty
  property p_out_stable;
    (!serial_select_n_i && fall_cnt >= 8'd16 && fall_cnt <= 8'd23
      && $changed(serial_data_out_o)) |-> rise_age <= 4'd7;
  endproperty
  property p_pwr_alert;
    $rose(power_button_event_i) |-> ##[1:4] host_alert_out_o;
  endproperty
  property p_alert_hold;
    s_idle_alert |=> host_alert_out_o;
  endproperty
  property p_reset_quiet;
    $fell(rst_i) |-> !host_alert_out_o && !serial_data_oe_o && !serial_data_out_o;
  endproperty

  a_oe_off: assert property (p_oe_off) else $error("data output driven while deselected");
  a_oe_on: assert property (p_oe_on) else $error("data output not driven in frame");
  a_out_idle: assert property (p_out_idle) else $error("data output not low when idle");
  a_out_zero_head: assert property (p_out_zero_head) else $error("nonzero head bits");
  a_out_stable: assert property (p_out_stable) else $error("data changed off rising edge");
  a_pwr_alert: assert property (p_pwr_alert) else $error("button edge gave no alert");
  a_alert_hold: assert property (p_alert_hold) else $error("alert dropped without access");
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after reset");
endmodule // srp_top_sva

bind srp_top srp_top_sva #(.MAX_PACKETS(MAX_PACKETS)) i_srp_top_sva (
  .clk_i(clk_i), .rst_i(rst_i), .serial_clock_in_i(serial_clock_in_i),
  .serial_select_n_i(serial_select_n_i), .serial_data_in_i(serial_data_in_i),
  .serial_data_out_o(serial_data_out_o), .serial_data_oe_o(serial_data_oe_o),
  .host_alert_out_o(host_alert_out_o), .power_button_event_i(power_button_event_i),
  .converter_src_i(converter_src_i), .clock_alarm_src_i(clock_alarm_src_i),
  .pin_edge_src_i(pin_edge_src_i), .regulator_fault_src_i(regulator_fault_src_i));

// File: verif/srp_master_model.sv
// system controller model that clocks frames into the register port
`timescale 1ns/1ps
module srp_master_model (
  input  wire logic clk_i,
  input  wire logic miso_i,
  output logic      sclk_o,
  output logic      csn_o,
  output logic      mosi_o
);
  // link clock idles low and select idles high
  initial begin
    sclk_o = 1'b0;
    csn_o  = 1'b1;
    mosi_o = 1'b0;
  end

  // one byte: launch on the rising link edge, sample on the falling one
  task automatic xfer_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      @(posedge clk_i);
      sclk_o <= 1'b1;
      mosi_o <= tx[i];
      repeat (8) @(posedge clk_i);
      rx[i] = miso_i;
      sclk_o <= 1'b0;
      repeat (7) @(posedge clk_i);
    end
  endtask

  // select stays low until close_frame
  task automatic open_frame();
    @(posedge clk_i);
    csn_o <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask

  // select raised between transfers; released data shows no stale bit
  task automatic close_frame();
    repeat (6) @(posedge clk_i);
    csn_o  <= 1'b1;
    mosi_o <= ~mosi_o;
    repeat (12) @(posedge clk_i);
  endtask

  // direction, address, zero dead bits, data; all msb first
  task automatic packet(input logic dir, input logic [9:0] addr, input logic [7:0] dat,
                        output logic [23:0] rx);
    logic [23:0] tx;
    tx = {dir, addr, 5'h00, dat};
    xfer_byte(tx[23:16], rx[23:16]);
    xfer_byte(tx[15:8], rx[15:8]);
    xfer_byte(tx[7:0], rx[7:0]);
  endtask
endmodule // srp_master_model

// File: verif/test_srp_top.sv
// self-checking bench for the serial register port and interrupt tree
`timescale 1ns/1ps
`include "srp_params.svh"
module test_srp_top
  import srp_pkg::*;
;
  logic        clk_i;
  logic        rst_i;
  logic        sclk, csn, mosi, miso_w, data_out, data_oe, alert, pwr_evt;
  logic [7:0]  conv_src, rtc_src, pin_src, vr_src;
  logic [23:0] rx;
  srp_byte_t   b2;
  logic [9:0]  rst_addr [9];
  srp_byte_t   rst_val  [9];
  int          failures, n_tests, cycles;

  assign miso_w = data_oe ? data_out : 1'bz;

  srp_top i_srp_top (
    .clk_i(clk_i), .rst_i(rst_i), .serial_clock_in_i(sclk), .serial_select_n_i(csn),
    .serial_data_in_i(mosi), .serial_data_out_o(data_out), .serial_data_oe_o(data_oe),
    .host_alert_out_o(alert), .power_button_event_i(pwr_evt), .converter_src_i(conv_src),
    .clock_alarm_src_i(rtc_src), .pin_edge_src_i(pin_src), .regulator_fault_src_i(vr_src));

  srp_master_model i_srp_master_model (
    .clk_i(clk_i), .miso_i(miso_w), .sclk_o(sclk), .csn_o(csn), .mosi_o(mosi));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // hang guard
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      failures++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input srp_byte_t got, input srp_byte_t exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_alert(input logic e);
    repeat (4) @(posedge clk_i);
    chk({7'h00, alert}, {7'h00, e});
  endtask

  task automatic wr(input logic [9:0] a, input srp_byte_t d);
    i_srp_master_model.open_frame();
    i_srp_master_model.packet(1'b1, a, d, rx);
    i_srp_master_model.close_frame();
  endtask

  // data sent during a read is noise the port must ignore
  task automatic rd(input logic [9:0] a, input srp_byte_t exp);
    i_srp_master_model.open_frame();
    i_srp_master_model.packet(1'b0, a, 8'h5a, rx);
    i_srp_master_model.close_frame();
    chk(rx[23:16], 8'h00);
    chk(rx[15:8], 8'h00);
    chk(rx[7:0], exp);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_i = 1'b1;
    pwr_evt = 1'b0;
    conv_src = 8'h00;
    rtc_src = 8'h00;
    pin_src = 8'h00;
    vr_src = 8'h00;
    failures = 0;
    n_tests = 0;
    cycles = 0;
    rst_addr = '{`SRP_ADDR_TOP_FLAGS, `SRP_ADDR_TOP_MASKS, `SRP_ADDR_RTC_FLAGS,
                 `SRP_ADDR_VR_FLAGS, `SRP_ADDR_VR_MASKS, `SRP_ADDR_ADC_FLAGS,
                 `SRP_ADDR_ADC_MASKS, `SRP_ADDR_PIN_FLAGS, 10'h3ff};
    rst_val = '{8'h00, 8'hfa, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00};
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    for (int i = 0; i < 9; i++) begin
      rd(rst_addr[i], rst_val[i]);
    end
    chk_alert(1'b0);
    wr(`SRP_ADDR_VR_MASKS, 8'h05);
    rd(`SRP_ADDR_VR_MASKS, 8'h05);
    wr(`SRP_ADDR_TOP_FLAGS, 8'hff);
    rd(`SRP_ADDR_TOP_FLAGS, 8'h00);
    wr(10'h3ff, 8'h11);
    rd(10'h3ff, 8'h00);
    // eight write packets under one select; the ninth is dropped
    i_srp_master_model.open_frame();
    for (int i = 0; i < 9; i++) begin
      i_srp_master_model.packet(1'b1, (i < 8) ? `SRP_ADDR_PIN_CTL0 + 10'(i)
                                : `SRP_ADDR_TOP_MASKS, 8'h30, rx);
    end
    i_srp_master_model.close_frame();
    for (int i = 0; i < 8; i++) begin
      rd(`SRP_ADDR_PIN_CTL0 + 10'(i), 8'h30);
    end
    rd(`SRP_ADDR_TOP_MASKS, 8'hfa);
    // two bytes in one read: flags then the next address
    i_srp_master_model.open_frame();
    i_srp_master_model.packet(1'b0, `SRP_ADDR_VR_FLAGS, 8'h00, rx);
    i_srp_master_model.xfer_byte(8'h00, b2);
    i_srp_master_model.close_frame();
    chk(rx[7:0], 8'h00);
    chk(b2, 8'h05);
    // button, converter and regulator groups unmasked at top level
    wr(`SRP_ADDR_TOP_MASKS, 8'hd8);
    @(posedge clk_i) pwr_evt <= 1'b1;
    @(posedge clk_i) pwr_evt <= 1'b0;
    chk_alert(1'b1);
    rd(`SRP_ADDR_TOP_FLAGS, 8'h01);
    chk_alert(1'b0);
    // regulator event masked at second level
    @(posedge clk_i) vr_src <= 8'h01;
    @(posedge clk_i) vr_src <= 8'h00;
    chk_alert(1'b0);
    wr(`SRP_ADDR_VR_MASKS, 8'h04);
    chk_alert(1'b1);
    rd(`SRP_ADDR_TOP_FLAGS, 8'h20);
    chk_alert(1'b0);
    rd(`SRP_ADDR_VR_FLAGS, 8'h01);
    rd(`SRP_ADDR_VR_FLAGS, 8'h00);
    @(posedge clk_i) vr_src <= 8'h01;
    @(posedge clk_i) vr_src <= 8'h00;
    chk_alert(1'b1);
    rd(`SRP_ADDR_TOP_FLAGS, 8'h20);
    rd(`SRP_ADDR_VR_FLAGS - 10'h001, 8'h00);
    rd(`SRP_ADDR_VR_FLAGS, 8'h01);
    // converter level source held across reads
    @(posedge clk_i) conv_src <= 8'h01;
    chk_alert(1'b1);
    rd(`SRP_ADDR_TOP_FLAGS, 8'h02);
    rd(`SRP_ADDR_ADC_FLAGS, 8'h01);
    rd(`SRP_ADDR_TOP_FLAGS, 8'h02);
    @(posedge clk_i) conv_src <= 8'h02;
    @(posedge clk_i) conv_src <= 8'h00;
    rd(`SRP_ADDR_TOP_FLAGS, 8'h00);
    rd(`SRP_ADDR_ADC_FLAGS, 8'h03);
    rd(`SRP_ADDR_ADC_FLAGS, 8'h00);
    // converter event masked at second level still latches
    wr(`SRP_ADDR_ADC_MASKS, 8'h01);
    @(posedge clk_i) conv_src <= 8'h01;
    @(posedge clk_i) conv_src <= 8'h00;
    chk_alert(1'b0);
    rd(`SRP_ADDR_ADC_FLAGS, 8'h01);
    // alarm group: reserved positions never latch
    @(posedge clk_i) rtc_src <= 8'h21;
    @(posedge clk_i) rtc_src <= 8'h00;
    rd(`SRP_ADDR_RTC_FLAGS, 8'h20);
    // pin events gated by the prevention field
    @(posedge clk_i) pin_src <= 8'h01;
    @(posedge clk_i) pin_src <= 8'h00;
    rd(`SRP_ADDR_PIN_FLAGS, 8'h00);
    wr(`SRP_ADDR_PIN_CTL0, 8'h00);
    @(posedge clk_i) pin_src <= 8'h01;
    @(posedge clk_i) pin_src <= 8'h00;
    rd(`SRP_ADDR_PIN_FLAGS, 8'h01);
    end_sim();
  end
endmodule // test_srp_top
